//--- verilog/port0_mux_consts.svh
`ifndef PORT0_MUX_CONSTS_SVH
`define PORT0_MUX_CONSTS_SVH

// pin counts
`define P0_PINS            6
`define CTRL_PINS          5

// register byte addresses
`define EBS_OFFSET         16'h1C00
`define PIN_STATUS_OFFSET  16'h1C04

// external_bus_select layout and reset value
`define EBS_RESET          16'h0000
`define ROUTE_SEL_LSB      8
`define ROUTE_SEL_MSB      9
`define CLK_SRC_BIT        15
`define HOST_SEL_BIT       0

// route_sel encodings
`define ROUTE_CARD         2'h0
`define ROUTE_AUDIO        2'h1
`define ROUTE_GPIO         2'h2
`define ROUTE_BSP          2'h3

// levels handed to functions that do not own the pins
`define P0_IDLE_IN         6'h00
`define CTRL_IDLE_IN       5'h00
`define AUDIO_IDLE_IN      4'h0
`define BSP_IDLE_IN        5'h00

`endif

//--- verilog/port0_mux_pkg.sv
`default_nettype none
`include "port0_mux_consts.svh"

package port0_mux_pkg;

  typedef enum logic [1:0]
  {
    ROUTE_CARD  = `ROUTE_CARD,
    ROUTE_AUDIO = `ROUTE_AUDIO,
    ROUTE_GPIO  = `ROUTE_GPIO,
    ROUTE_BSP   = `ROUTE_BSP
  } route_mode_t;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  typedef struct packed
  {
    logic [`P0_PINS-1:0] out;
    logic [`P0_PINS-1:0] oe;
  } pin_drive_t;

  typedef struct packed
  {
    logic [`CTRL_PINS-1:0] out;
    logic [`CTRL_PINS-1:0] oe;
  } ctrl_drive_t;

endpackage

`default_nettype wire

//--- verilog/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // two flops per bit; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_r;
      logic stable_r;
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
        end
        else
        begin
          meta_r   <= async_in[i];
          stable_r <= meta_r;
        end
      end
      assign sync_out[i] = stable_r;
    end
  endgenerate

endmodule

`default_nettype wire

//--- verilog/ctrl_pin_sel.sv
`timescale 1ns/100ps
`default_nettype none
`include "port0_mux_consts.svh"

module ctrl_pin_sel
(
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       host_sel,
  input  wire logic [`CTRL_PINS-1:0]      pin_sync_in,
  input  wire port0_mux_pkg::ctrl_drive_t sdram_drv,
  input  wire port0_mux_pkg::ctrl_drive_t host_drv,
  output logic      [`CTRL_PINS-1:0]      pin_out,
  output logic      [`CTRL_PINS-1:0]      pin_oe,
  output logic      [`CTRL_PINS-1:0]      sdram_in,
  output logic      [`CTRL_PINS-1:0]      host_in
);

  import port0_mux_pkg::*;

  always_comb
  begin
    if (host_sel)
    begin
      pin_out  = host_drv.out;   // RULE7
      pin_oe   = host_drv.oe;
      host_in  = pin_sync_in;
      sdram_in = `CTRL_IDLE_IN;  // RULE8
    end
    else
    begin
      pin_out  = sdram_drv.out;  // RULE7
      pin_oe   = sdram_drv.oe;
      sdram_in = pin_sync_in;
      host_in  = `CTRL_IDLE_IN;  // RULE8
    end
  end

  ctrl_owner_a: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    (host_sel ? (pin_oe == host_drv.oe && sdram_in == `CTRL_IDLE_IN)
              : (pin_oe == sdram_drv.oe && host_in == `CTRL_IDLE_IN)))
    else $error("control pins not owned by selected controller");

endmodule

`default_nettype wire

//--- verilog/serial_port0_pin_mux.sv
// Overview of operation
// RULE1: a two-bit route field in external_bus_select picks one of four pin functions.
// RULE2: route 00, the reset value, puts card clock, command and data0-3 on pins.
// RULE3: route 01 puts audio clock, frame, tx, rx on pins 0-3, gpio 4-5 above.
// RULE4: route 10 puts gpio lines 0 to 5 on the six pins in order.
// RULE5: route 11 puts buffered serial tx clk, tx fs, tx, rx, rx fs, clock pin.
// RULE6: in route 11, register bit 15 picks rx clock or clock source for pin 5.
// RULE7: a register bit picks sdram or host port control on five shared pins.
// RULE8: routing is combinational on registered mode; unselected inputs sit at idle level.
`timescale 1ns/100ps
`default_nettype none
`include "port0_mux_consts.svh"

module serial_port0_pin_mux
(
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // avalon-mm slave
  input  wire logic [15:0]                address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  // six shared serial port 0 pins
  input  wire logic [`P0_PINS-1:0]        pin_in,
  output logic      [`P0_PINS-1:0]        pin_out,
  output logic      [`P0_PINS-1:0]        pin_oe,
  // on-chip functions
  input  wire port0_mux_pkg::pin_drive_t  card_drv,
  output logic      [`P0_PINS-1:0]        card_in,
  input  wire port0_mux_pkg::pin_drive_t  audio_drv,
  output logic      [3:0]                 audio_in,
  input  wire port0_mux_pkg::pin_drive_t  gpio_drv,
  output logic      [`P0_PINS-1:0]        gpio_in,
  input  wire port0_mux_pkg::pin_drive_t  bsp_drv,
  output logic      [4:0]                 bsp_in,
  output logic                            bsp_rx_clock,
  output logic                            bsp_clock_source,
  // five shared control pins
  input  wire logic [`CTRL_PINS-1:0]      ctrl_pin_in,
  output logic      [`CTRL_PINS-1:0]      ctrl_pin_out,
  output logic      [`CTRL_PINS-1:0]      ctrl_pin_oe,
  input  wire port0_mux_pkg::ctrl_drive_t sdram_drv,
  output logic      [`CTRL_PINS-1:0]      sdram_in,
  input  wire port0_mux_pkg::ctrl_drive_t host_drv,
  output logic      [`CTRL_PINS-1:0]      host_in
);

  import port0_mux_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  bus_state_t              bus_state_r;
  bus_state_t              bus_state_nxt;
  route_mode_t             route_sel_r;
  logic                    clk_src_r;
  logic                    host_sel_r;
  logic [31:0]             readdata_r;
  logic [31:0]             readdata_nxt;
  logic [`P0_PINS-1:0]     pin_s;
  logic [`CTRL_PINS-1:0]   ctrl_s;
  logic                    req;
  logic                    ebs_hit;
  logic                    status_hit;
  logic                    wr_take;
  logic [15:0]             ebs_view;

  pin_sync #(
    .WIDTH    (`P0_PINS + `CTRL_PINS)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({ctrl_pin_in, pin_in}),
    .sync_out ({ctrl_s, pin_s})
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state on every access, so readdata is always registered

  assign req         = read | write;
  assign ebs_hit     = (address == `EBS_OFFSET);
  assign status_hit  = (address == `PIN_STATUS_OFFSET);
  assign waitrequest = req && (bus_state_r == BUS_IDLE);
  assign wr_take     = write && (bus_state_r == BUS_ACK);
  assign readdata    = readdata_r;

  always_comb
  begin
    ebs_view                                 = 16'h0000;
    ebs_view[`ROUTE_SEL_MSB:`ROUTE_SEL_LSB]  = route_sel_r;
    ebs_view[`CLK_SRC_BIT]                   = clk_src_r;
    ebs_view[`HOST_SEL_BIT]                  = host_sel_r;
  end

  always_comb
  begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      BUS_IDLE:
      begin
        if (req)
        begin
          bus_state_nxt = BUS_ACK;
        end
      end
      BUS_ACK:
      begin
        bus_state_nxt = BUS_IDLE;
      end
      default:
      begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_state_r <= BUS_IDLE;
    end
    else
    begin
      bus_state_r <= bus_state_nxt;
    end
  end

  // unmapped reads answer zero, unmapped writes are dropped
  always_comb
  begin
    readdata_nxt = 32'h0000_0000;
    if (ebs_hit)
    begin
      readdata_nxt = {16'h0000, ebs_view};
    end
    else if (status_hit)
    begin
      readdata_nxt = {21'h00_0000, ctrl_s, pin_s};
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      readdata_r <= 32'h0000_0000;
    end
    else if (read && bus_state_r == BUS_IDLE)
    begin
      readdata_r <= readdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      route_sel_r <= ROUTE_CARD;                                               // RULE2
      clk_src_r   <= 1'b0;
      host_sel_r  <= 1'b0;
    end
    else if (wr_take && ebs_hit)
    begin
      if (byteenable[1])
      begin
        route_sel_r <= route_mode_t'(writedata[`ROUTE_SEL_MSB:`ROUTE_SEL_LSB]); // RULE1
        clk_src_r   <= writedata[`CLK_SRC_BIT];                                // RULE6
      end
      if (byteenable[0])
      begin
        host_sel_r  <= writedata[`HOST_SEL_BIT];                               // RULE7
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin routing: purely combinational, so a mode write reroutes on the next cycle

  always_comb
  begin
    pin_out = card_drv.out;
    pin_oe  = card_drv.oe;
    case (route_sel_r)
      ROUTE_CARD:
      begin
        pin_out = card_drv.out;                                  // RULE2
        pin_oe  = card_drv.oe;
      end
      ROUTE_AUDIO:
      begin
        pin_out = {gpio_drv.out[5:4], audio_drv.out[3:0]};       // RULE3
        pin_oe  = {gpio_drv.oe[5:4], audio_drv.oe[3:0]};
      end
      ROUTE_GPIO:
      begin
        pin_out = gpio_drv.out;                                  // RULE4
        pin_oe  = gpio_drv.oe;
      end
      ROUTE_BSP:
      begin
        pin_out = bsp_drv.out;                                   // RULE5
        pin_oe  = bsp_drv.oe;
        // clock source is an input only; never fight an external oscillator
        if (clk_src_r)
        begin
          pin_oe[5] = 1'b0;                                      // RULE6
        end
      end
      default:
      begin
        pin_out = card_drv.out;
        pin_oe  = card_drv.oe;
      end
    endcase
  end

  // inputs return only to the owner; others see idle so no false edges
  always_comb
  begin
    card_in          = `P0_IDLE_IN;                              // RULE8
    audio_in         = `AUDIO_IDLE_IN;
    gpio_in          = `P0_IDLE_IN;
    bsp_in           = `BSP_IDLE_IN;
    bsp_rx_clock     = 1'b0;
    bsp_clock_source = 1'b0;
    case (route_sel_r)
      ROUTE_CARD:
      begin
        card_in = pin_s;                                         // RULE2
      end
      ROUTE_AUDIO:
      begin
        audio_in     = pin_s[3:0];                               // RULE3
        gpio_in[5:4] = pin_s[5:4];
      end
      ROUTE_GPIO:
      begin
        gpio_in = pin_s;                                         // RULE4
      end
      ROUTE_BSP:
      begin
        bsp_in = pin_s[4:0];                                     // RULE5
        if (clk_src_r)
        begin
          bsp_clock_source = pin_s[5];                           // RULE6
        end
        else
        begin
          bsp_rx_clock = pin_s[5];                               // RULE6
        end
      end
      default:
      begin
        card_in = pin_s;
      end
    endcase
  end

  ctrl_pin_sel u_ctrl_pin_sel (
    .core_clk    (core_clk),
    .rst         (rst),
    .host_sel    (host_sel_r),
    .pin_sync_in (ctrl_s),
    .sdram_drv   (sdram_drv),
    .host_drv    (host_drv),
    .pin_out     (ctrl_pin_out),
    .pin_oe      (ctrl_pin_oe),
    .sdram_in    (sdram_in),
    .host_in     (host_in)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence bus_wait_s;
    req && waitrequest;
  endsequence

  sequence bus_done_s;
    req && !waitrequest;
  endsequence

  sequence ebs_mode_write_s;
    wr_take && ebs_hit && byteenable[1];
  endsequence

  bus_answer_a: assert property (@(posedge core_clk) disable iff (rst)
    bus_wait_s |=> bus_done_s ##1 (waitrequest == req))
    else $error("bus access not answered after one wait state");

  mode_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    ebs_mode_write_s |=> route_sel_r == $past(writedata[9:8]) && clk_src_r == $past(writedata[15]))
    else $error("route field did not take written value");

  card_route_a: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    route_sel_r == ROUTE_CARD |-> pin_out == card_drv.out && pin_oe == card_drv.oe
                                  && card_in == pin_s)
    else $error("card function not on pins");

  audio_route_a: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    route_sel_r == ROUTE_AUDIO |-> pin_out[3:0] == audio_drv.out[3:0]
                                   && pin_out[5:4] == gpio_drv.out[5:4]
                                   && gpio_in == {pin_s[5:4], 4'h0})
    else $error("audio plus gpio routing wrong");

  gpio_route_a: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    route_sel_r == ROUTE_GPIO |-> pin_oe == gpio_drv.oe && gpio_in == pin_s)
    else $error("gpio routing wrong");

  bsp_route_a: assert property (@(posedge core_clk) disable iff (rst) // RULE5
    route_sel_r == ROUTE_BSP |-> pin_out == bsp_drv.out && bsp_in == pin_s[4:0])
    else $error("buffered serial routing wrong");

  clk_pick_a: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    route_sel_r == ROUTE_BSP |-> (clk_src_r ? (bsp_clock_source == pin_s[5] && !bsp_rx_clock
                                               && !pin_oe[5])
                                            : (bsp_rx_clock == pin_s[5] && !bsp_clock_source)))
    else $error("sixth pin clock selection wrong");

  host_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    wr_take && ebs_hit && byteenable[0] |=> host_sel_r == $past(writedata[0]))
    else $error("control pin owner not updated");

  idle_inputs_a: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    route_sel_r != ROUTE_CARD |-> card_in == 6'h00
                                  && (route_sel_r == ROUTE_AUDIO || audio_in == 4'h0)
                                  && (route_sel_r == ROUTE_BSP
                                      || (bsp_in == 5'h00 && !bsp_rx_clock
                                          && !bsp_clock_source)))
    else $error("unselected function sees live pin input");

endmodule

`default_nettype wire

//--- dv/ext_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module ext_pin_model #(
  parameter int W = 6
) (
  input  wire logic [W-1:0] drv_out,
  input  wire logic [W-1:0] drv_oe,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] level
);
  // far devices drive only the pins the block has released, so no fight on the wire
  assign level = (drv_oe & drv_out) | (~drv_oe & ext_val);
endmodule

`default_nettype wire

//--- dv/test_serial_port0_pin_mux.sv
`timescale 1ns/100ps
`default_nettype none
`include "port0_mux_consts.svh"

module test_serial_port0_pin_mux;
  import port0_mux_pkg::*;
  logic        core_clk;
  logic        rst;
  logic [15:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [5:0]  pin_in;
  logic [5:0]  pin_out;
  logic [5:0]  pin_oe;
  logic [5:0]  card_in;
  logic [5:0]  gpio_in;
  logic [5:0]  ext6;
  logic [5:0]  lv;
  logic [3:0]  audio_in;
  logic [4:0]  bsp_in;
  logic        bsp_rx_clock;
  logic        bsp_clock_source;
  logic [4:0]  ctrl_pin_in;
  logic [4:0]  ctrl_pin_out;
  logic [4:0]  ctrl_pin_oe;
  logic [4:0]  sdram_in;
  logic [4:0]  host_in;
  logic [4:0]  ext5;
  logic [4:0]  cl;
  logic [15:0] ebs_m;
  logic [31:0] q;
  logic [31:0] r;
  pin_drive_t  card_drv;
  pin_drive_t  audio_drv;
  pin_drive_t  gpio_drv;
  pin_drive_t  bsp_drv;
  ctrl_drive_t sdram_drv;
  ctrl_drive_t host_drv;
  int          n_fail;
  int          check_count;
  int          cyc;
  int          seed;

  serial_port0_pin_mux serial_port0_pin_mux_inst (
    .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .card_drv(card_drv), .card_in(card_in), .audio_drv(audio_drv), .audio_in(audio_in),
    .gpio_drv(gpio_drv), .gpio_in(gpio_in), .bsp_drv(bsp_drv), .bsp_in(bsp_in),
    .bsp_rx_clock(bsp_rx_clock), .bsp_clock_source(bsp_clock_source),
    .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_out(ctrl_pin_out), .ctrl_pin_oe(ctrl_pin_oe),
    .sdram_drv(sdram_drv), .sdram_in(sdram_in), .host_drv(host_drv), .host_in(host_in));
  ext_pin_model #(.W(6)) pins_inst (.drv_out(pin_out), .drv_oe(pin_oe), .ext_val(ext6),
    .level(pin_in));
  ext_pin_model #(.W(5)) ctrl_inst (.drv_out(ctrl_pin_out), .drv_oe(ctrl_pin_oe),
    .ext_val(ext5), .level(ctrl_pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one request, held until waitrequest is sampled low; the model follows the write
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    chk(n >= 50, 32'h0);
    if (wr && a == `EBS_OFFSET && be[0])
      ebs_m[7:0] = d[7:0];
    if (wr && a == `EBS_OFFSET && be[1])
      ebs_m[15:8] = d[15:8];
  endtask

  task automatic expect_all(input bit full);
    logic [1:0] rt;
    logic       cs;
    logic       hs;
    logic [5:0] eo;
    logic [5:0] ee;
    logic [4:0] co;
    logic [4:0] ce;
    rt = ebs_m[`ROUTE_SEL_MSB:`ROUTE_SEL_LSB];
    cs = ebs_m[`CLK_SRC_BIT];
    hs = ebs_m[`HOST_SEL_BIT];
    eo = (rt == 2'h0) ? card_drv.out : (rt == 2'h2) ? gpio_drv.out : (rt == 2'h1) ?
         {gpio_drv.out[5:4], audio_drv.out[3:0]} : bsp_drv.out;
    ee = (rt == 2'h0) ? card_drv.oe : (rt == 2'h2) ? gpio_drv.oe : (rt == 2'h1) ?
         {gpio_drv.oe[5:4], audio_drv.oe[3:0]} : bsp_drv.oe;
    if (rt == 2'h3 && cs)
      ee[5] = 1'b0;
    co = hs ? host_drv.out : sdram_drv.out;
    ce = hs ? host_drv.oe : sdram_drv.oe;
    lv = (ee & eo) | (~ee & ext6);
    cl = (ce & co) | (~ce & ext5);
    chk(pin_oe, ee);
    chk(pin_out & pin_oe, eo & ee);
    chk({ctrl_pin_oe, ctrl_pin_out & ctrl_pin_oe}, {ce, co & ce});
    if (full)
    begin
      chk(card_in, rt == 2'h0 ? lv : 6'h00);
      chk(audio_in, rt == 2'h1 ? lv[3:0] : 4'h0);
      chk(gpio_in, rt == 2'h2 ? lv : rt == 2'h1 ? {lv[5:4], 4'h0} : 6'h00);
      chk(bsp_in, rt == 2'h3 ? lv[4:0] : 5'h00);
      chk({bsp_rx_clock, bsp_clock_source}, {rt == 2'h3 && !cs && lv[5],
          rt == 2'h3 && cs && lv[5]});
      chk({sdram_in, host_in}, hs ? {5'h00, cl} : {cl, 5'h00});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // a hang must still reach the verdict
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    {rst, read, write} = 3'b100;
    {address, writedata, byteenable} = '0;
    {card_drv, audio_drv, gpio_drv, bsp_drv, sdram_drv, host_drv} = '0;
    {ext6, ext5, n_fail, check_count, ebs_m} = '0;
    seed = 32'h6ab56e94;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, `EBS_OFFSET, 32'h0, 4'hF);
    chk(q, 32'h0);
    for (int i = 0; i < 48; i++)
    begin
      r = $random(seed);
      // first pass writes both low lanes so every route and select combination is set
      bus(1'b1, `EBS_OFFSET, {r[31:16], i[3], r[14:10], i[1:0], r[7:1], i[2]},
          i < 16 ? {r[3:2], 2'h3} : r[3:0]);
      #1;
      expect_all(1'b0);
      @(posedge core_clk);
      card_drv <= 12'($random(seed));
      audio_drv <= 12'($random(seed));
      gpio_drv <= 12'($random(seed));
      bsp_drv <= 12'($random(seed));
      sdram_drv <= 10'($random(seed));
      host_drv <= 10'($random(seed));
      r = $random(seed);
      ext6 <= r[5:0];
      ext5 <= r[12:8];
      repeat (3) @(posedge core_clk);
      #1;
      expect_all(1'b1);
      if (i % 4 == 0)
      begin
        bus(1'b1, 16'h1C08, r, 4'hF);
        bus(1'b1, `PIN_STATUS_OFFSET, r, 4'hF);
        bus(1'b0, 16'h1C08, 32'h0, 4'hF);
        chk(q, 32'h0);
      end
      bus(1'b0, `EBS_OFFSET, 32'h0, 4'hF);
      chk(q, {16'h0, ebs_m & 16'h8301});
      bus(1'b0, `PIN_STATUS_OFFSET, 32'h0, 4'hF);
      chk(q, {21'h0, cl, lv});
    end
    // reset in mid-run returns the card route and sdram control
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    ebs_m = `EBS_RESET;
    #1;
    expect_all(1'b0);
    bus(1'b0, `EBS_OFFSET, 32'h0, 4'hF);
    chk(q, 32'h0);
    results();
  end
endmodule

`default_nettype wire
